// File: src/smap_pkg.sv
// Constants, register map and encodings of the stop mode and alarm parameter block
package smap_pkg;

  // ==========================================================
  // Register word addresses (32-bit objects take two words, low first)
  localparam logic [15:0] ADDR_FAST_DECEL_LO = 16'h3300;
  localparam logic [15:0] ADDR_FAST_DECEL_HI = 16'h3301;
  localparam logic [15:0] ADDR_FAST_SEL = 16'h3400;
  localparam logic [15:0] ADDR_ENW_SEL = 16'h3410;
  localparam logic [15:0] ADDR_DIS_SEL = 16'h3420;
  localparam logic [15:0] ADDR_PAUSE_SEL = 16'h3430;
  localparam logic [15:0] ADDR_FAULT_SEL = 16'h3440;
  localparam logic [15:0] ADDR_RESTART = 16'h2F00;
  localparam logic [15:0] ADDR_PROF_DECEL_LO = 16'h4C00;
  localparam logic [15:0] ADDR_PROF_DECEL_HI = 16'h4C01;
  localparam logic [15:0] ADDR_HEAT_LIMIT = 16'h7180;
  localparam logic [15:0] ADDR_HEAT_READ = 16'h7190;
  localparam logic [15:0] ADDR_LOW_LIMIT = 16'h8670;
  localparam logic [15:0] ADDR_CHOP = 16'h8680;
  localparam logic [15:0] ADDR_HIGH_LIMIT = 16'h8690;
  localparam logic [15:0] ADDR_PARAM_SRC = 16'h7200;
  localparam logic [15:0] ADDR_SIM_RES = 16'h7210;
  localparam logic [15:0] ADDR_ALARM = 16'h1F00;

  // ==========================================================
  // Reset values (deceleration in units of 0.01 rps/s)
  localparam logic [15:0] SEL_RST = 16'h0000;
  localparam logic [15:0] PAUSE_SEL_RST = 16'h0001;
  localparam logic [31:0] PROF_DECEL_RST = 32'h0000_2710;
  localparam logic [31:0] FAST_DECEL_RST = 32'h0000_EE48;
  localparam logic [15:0] HEAT_LIMIT_RST = 16'h0064;
  localparam logic [15:0] LOW_LIMIT_RST = 16'h0012;
  localparam logic [15:0] CHOP_RST = 16'h003F;
  localparam logic [15:0] HIGH_LIMIT_RST = 16'h0046;
  localparam logic [7:0] PARAM_SRC_RST = 8'h02;
  localparam logic [7:0] PARAM_SRC_MAX = 8'h02;

  // ==========================================================
  // Stop selection values
  localparam logic [15:0] SEL_FREE = 16'h0000;
  localparam logic [15:0] SEL_RAMP = 16'h0001;
  localparam logic [15:0] SEL_QUICK = 16'h0002;
  localparam logic [15:0] SEL_PROF_HOLD = 16'h0005;
  localparam logic [15:0] SEL_QUICK_HOLD = 16'h0006;
  localparam logic [15:0] SEL_WINDING = 16'h0012;

  // Stop action kinds driven out of the block
  localparam logic [2:0] KIND_NONE = 3'h0;
  localparam logic [2:0] KIND_FREE = 3'h1;
  localparam logic [2:0] KIND_RAMP = 3'h2;
  localparam logic [2:0] KIND_QUICK = 3'h3;
  localparam logic [2:0] KIND_WINDING = 3'h4;

  // ==========================================================
  // Commands, control word and field positions
  localparam logic [15:0] CW_QUICK_STOP = 16'h000B;
  localparam int CW_PAUSE_BIT = 8;
  localparam logic [15:0] CMD_BOOT = 16'h55AA;
  localparam logic [15:0] CMD_RESTART = 16'hAA55;
  localparam logic [15:0] TEMP_NO_SENSOR = 16'hFFD8;
  localparam int ALARM_OVER_BIT = 5;
  localparam int ALARM_UNDER_BIT = 6;
  localparam logic [15:0] SIM_RES_A = 16'h0FA0;
  localparam logic [15:0] SIM_RES_B = 16'h1F40;
  localparam logic [15:0] SIM_RES_C = 16'h2710;
  localparam logic [7:0] MODE_PROFILE_A = 8'h01;
  localparam logic [7:0] MODE_PROFILE_B = 8'h03;
  localparam int SYNC_WIDTH = 2;

endpackage

// File: src/smap_sync.sv
// Two-stage synchroniser for the limit and emergency stop pins
`timescale 1ns/1ps
`default_nettype none
module smap_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Pins and synchronised levels
  input wire logic [smap_pkg::SYNC_WIDTH-1:0] i_pin,
  output logic [smap_pkg::SYNC_WIDTH-1:0] o_level
);
  typedef struct packed {
    logic [smap_pkg::SYNC_WIDTH-1:0] meta;
    logic [smap_pkg::SYNC_WIDTH-1:0] stable;
  } smap_sync_s;

  smap_sync_s sync_reg;
  smap_sync_s sync_next;

  // First stage feeds only the second stage
  always_comb begin
    sync_next = sync_reg;
    for (int b = 0; b < smap_pkg::SYNC_WIDTH; b++) begin
      sync_next.meta[b] = i_pin[b];
      sync_next.stable[b] = sync_reg.meta[b];
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign o_level = sync_reg.stable;
endmodule // smap_sync
`default_nettype wire

// File: src/smap_stop_decode.sv
// Maps a stop selection value to its braking action
`timescale 1ns/1ps
`default_nettype none
module smap_stop_decode (
  // Selection in force
  input wire logic [15:0] i_sel,
  // Decoded action
  output logic [2:0] o_kind,
  output logic o_off,
  output logic o_hold
);
  // Pure decode; refused values never reach the store
  always_comb begin
    o_kind = smap_pkg::KIND_NONE;
    o_off = 1'b0;
    o_hold = 1'b0;
    unique case (i_sel)
      smap_pkg::SEL_FREE: begin
        o_kind = smap_pkg::KIND_FREE;
        o_off = 1'b1;
      end
      smap_pkg::SEL_RAMP: begin
        o_kind = smap_pkg::KIND_RAMP;
        o_off = 1'b1;
      end
      smap_pkg::SEL_QUICK: begin
        o_kind = smap_pkg::KIND_QUICK;
        o_off = 1'b1;
      end
      smap_pkg::SEL_PROF_HOLD: begin
        o_kind = smap_pkg::KIND_RAMP;
        o_hold = 1'b1;
      end
      smap_pkg::SEL_QUICK_HOLD: begin
        o_kind = smap_pkg::KIND_QUICK;
        o_hold = 1'b1;
      end
      // Winding brake needs no encoder feedback
      smap_pkg::SEL_WINDING: begin
        o_kind = smap_pkg::KIND_WINDING;
        o_off = 1'b1;
      end
      default: begin
        o_kind = smap_pkg::KIND_NONE;
      end
    endcase
  end
endmodule // smap_stop_decode
`default_nettype wire

// File: src/smap_top.sv
// Stop mode selection, alarm thresholds and restart command parameter bank
`timescale 1ns/1ps
`default_nettype none
module smap_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Parameter register port
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_ack,
  output logic o_err,
  output logic [15:0] o_rdata,
  // Stop events
  input wire logic i_limit_pin,
  input wire logic i_estop_pin,
  input wire logic [15:0] i_ctrl_word,
  input wire logic i_drive_enable,
  input wire logic i_disable_req,
  input wire logic i_fault,
  input wire logic [7:0] i_work_mode,
  // Measurements
  input wire logic [15:0] i_motor_temp,
  input wire logic i_temp_sensor_ok,
  input wire logic [15:0] i_supply_volts,
  input wire logic i_enc_is_comm,
  // Stop action
  output logic [2:0] o_stop_kind,
  output logic o_switch_off,
  output logic o_qs_active,
  output logic o_pause_active,
  output logic [31:0] o_decel_rate,
  // Alarms and status
  output logic [15:0] o_temp_reading,
  output logic o_heat_alarm,
  output logic [15:0] o_alarm_status,
  output logic o_chopper_on,
  // Configuration and commands
  output logic [7:0] o_param_source,
  output logic o_boot_pulse,
  output logic o_restart_pulse,
  output logic o_sim_enc_en,
  output logic [15:0] o_sim_enc_res
);
  // ==========================================================
  // State
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_QSTOP = 4'b0010,
    ST_STOP = 4'b0100,
    ST_PAUSE = 4'b1000
  } smap_state_e;

  typedef struct packed {
    smap_state_e state;
    logic [15:0] fast_sel;
    logic [15:0] enw_sel;
    logic [15:0] dis_sel;
    logic [15:0] pause_sel;
    logic [15:0] fault_sel;
    logic [31:0] fast_decel;
    logic [31:0] prof_decel;
    logic [15:0] heat_limit;
    logic [15:0] low_limit;
    logic [15:0] chop;
    logic [15:0] high_limit;
    logic [7:0] src;
    logic [15:0] sim_res, sim_active, sim_out;
    logic [15:0] restart_val;
    logic ack, err;
    logic [15:0] rdata;
    logic [2:0] kind;
    logic sw_off, qs_hold, pause, qs_on;
    logic [31:0] decel;
    logic [15:0] temp;
    logic heat_alarm;
    logic [15:0] alarm;
    logic chop_on;
    logic boot, rst_pulse, sim_en;
  } smap_top_s;

  smap_top_s top_reg;
  smap_top_s top_next;

  // ==========================================================
  // Pin synchronisers and selection decode
  logic [1:0] pin_level;
  logic [15:0] act_sel;
  logic [2:0] dec_kind;
  logic dec_off;
  logic dec_hold;
  logic qs_evt;

  smap_sync smap_sync_inst (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_pin({i_estop_pin, i_limit_pin}),
    .o_level(pin_level)
  );

  smap_stop_decode smap_stop_decode_inst (
    .i_sel(act_sel),
    .o_kind(dec_kind),
    .o_off(dec_off),
    .o_hold(dec_hold)
  );

  // Quick stop sources
  assign qs_evt = pin_level[0] | pin_level[1] | (i_ctrl_word == smap_pkg::CW_QUICK_STOP);

  // Value checks that guard the fast, enable-withdrawal, disable and fault selection writes and the resolution write
  function automatic logic fast_ok(input logic [15:0] v);
    fast_ok = (v == smap_pkg::SEL_FREE) || (v == smap_pkg::SEL_RAMP) || (v == smap_pkg::SEL_QUICK) ||
              (v == smap_pkg::SEL_PROF_HOLD) || (v == smap_pkg::SEL_QUICK_HOLD) || (v == smap_pkg::SEL_WINDING);
  endfunction

  function automatic logic std_ok(input logic [15:0] v);
    std_ok = (v == smap_pkg::SEL_FREE) || (v == smap_pkg::SEL_RAMP) || (v == smap_pkg::SEL_QUICK) ||
             (v == smap_pkg::SEL_WINDING);
  endfunction

  function automatic logic res_ok(input logic [15:0] v);
    res_ok = (v == 16'h0000) || (v == smap_pkg::SIM_RES_A) || (v == smap_pkg::SIM_RES_B) ||
             (v == smap_pkg::SIM_RES_C);
  endfunction

  // ==========================================================
  // Stop selection by event priority: fault, quick stop, disable, shutdown, pause
  always_comb begin
    if (i_fault) begin
      act_sel = top_reg.fault_sel;
    end else if (qs_evt) begin
      act_sel = top_reg.fast_sel;
    end else if (i_disable_req) begin
      act_sel = top_reg.dis_sel;
    end else if (!i_drive_enable) begin
      act_sel = top_reg.enw_sel;
    end else begin
      act_sel = top_reg.pause_sel;
    end
  end

  // ==========================================================
  // Next state: register port, stop behaviour, alarms
  always_comb begin
    top_next = top_reg;
    top_next.ack = 1'b0;
    top_next.err = 1'b0;
    top_next.boot = 1'b0;
    top_next.rst_pulse = 1'b0;
    // Register port; refused writes keep the stored value
    if (i_req) begin
      top_next.ack = 1'b1;
      if (i_wr) begin
        unique case (i_addr)
          smap_pkg::ADDR_FAST_SEL: if (fast_ok(i_wdata)) top_next.fast_sel = i_wdata; else top_next.err = 1'b1;
          smap_pkg::ADDR_ENW_SEL: if (std_ok(i_wdata)) top_next.enw_sel = i_wdata; else top_next.err = 1'b1;
          smap_pkg::ADDR_DIS_SEL: if (std_ok(i_wdata)) top_next.dis_sel = i_wdata; else top_next.err = 1'b1;
          smap_pkg::ADDR_FAULT_SEL: if (std_ok(i_wdata)) top_next.fault_sel = i_wdata; else top_next.err = 1'b1;
          smap_pkg::ADDR_PAUSE_SEL: begin
            if (i_wdata == smap_pkg::SEL_RAMP || i_wdata == smap_pkg::SEL_QUICK) top_next.pause_sel = i_wdata;
            else top_next.err = 1'b1;
          end
          smap_pkg::ADDR_FAST_DECEL_LO: top_next.fast_decel[15:0] = i_wdata;
          smap_pkg::ADDR_FAST_DECEL_HI: top_next.fast_decel[31:16] = i_wdata;
          smap_pkg::ADDR_PROF_DECEL_LO: top_next.prof_decel[15:0] = i_wdata;
          smap_pkg::ADDR_PROF_DECEL_HI: top_next.prof_decel[31:16] = i_wdata;
          smap_pkg::ADDR_HEAT_LIMIT: top_next.heat_limit = i_wdata;
          smap_pkg::ADDR_LOW_LIMIT: top_next.low_limit = i_wdata;
          smap_pkg::ADDR_CHOP: top_next.chop = i_wdata;
          smap_pkg::ADDR_HIGH_LIMIT: top_next.high_limit = i_wdata;
          smap_pkg::ADDR_PARAM_SRC: begin
            if (i_wdata <= {8'h00, smap_pkg::PARAM_SRC_MAX}) top_next.src = i_wdata[7:0];
            else top_next.err = 1'b1;
          end
          smap_pkg::ADDR_SIM_RES: if (res_ok(i_wdata)) top_next.sim_res = i_wdata; else top_next.err = 1'b1;
          smap_pkg::ADDR_RESTART: begin
            top_next.restart_val = i_wdata;
            top_next.boot = (i_wdata == smap_pkg::CMD_BOOT);
            top_next.rst_pulse = (i_wdata == smap_pkg::CMD_RESTART);
            // Stored resolution only goes live at restart
            if (i_wdata == smap_pkg::CMD_RESTART) top_next.sim_active = top_reg.sim_res;
          end
          default: top_next.err = 1'b1;
        endcase
        top_next.rdata = 16'h0000;
      end else begin
        unique case (i_addr)
          smap_pkg::ADDR_FAST_SEL: top_next.rdata = top_reg.fast_sel;
          smap_pkg::ADDR_ENW_SEL: top_next.rdata = top_reg.enw_sel;
          smap_pkg::ADDR_DIS_SEL: top_next.rdata = top_reg.dis_sel;
          smap_pkg::ADDR_PAUSE_SEL: top_next.rdata = top_reg.pause_sel;
          smap_pkg::ADDR_FAULT_SEL: top_next.rdata = top_reg.fault_sel;
          smap_pkg::ADDR_FAST_DECEL_LO: top_next.rdata = top_reg.fast_decel[15:0];
          smap_pkg::ADDR_FAST_DECEL_HI: top_next.rdata = top_reg.fast_decel[31:16];
          smap_pkg::ADDR_PROF_DECEL_LO: top_next.rdata = top_reg.prof_decel[15:0];
          smap_pkg::ADDR_PROF_DECEL_HI: top_next.rdata = top_reg.prof_decel[31:16];
          smap_pkg::ADDR_HEAT_LIMIT: top_next.rdata = top_reg.heat_limit;
          smap_pkg::ADDR_HEAT_READ: top_next.rdata = top_reg.temp;
          smap_pkg::ADDR_LOW_LIMIT: top_next.rdata = top_reg.low_limit;
          smap_pkg::ADDR_CHOP: top_next.rdata = top_reg.chop;
          smap_pkg::ADDR_HIGH_LIMIT: top_next.rdata = top_reg.high_limit;
          smap_pkg::ADDR_PARAM_SRC: top_next.rdata = {8'h00, top_reg.src};
          smap_pkg::ADDR_SIM_RES: top_next.rdata = top_reg.sim_res;
          smap_pkg::ADDR_RESTART: top_next.rdata = top_reg.restart_val;
          smap_pkg::ADDR_ALARM: top_next.rdata = top_reg.alarm;
          default: begin
            top_next.rdata = 16'h0000;
            top_next.err = 1'b1;
          end
        endcase
      end
    end
    // Stop state follows the highest event present
    if (i_fault || qs_evt || i_disable_req || !i_drive_enable) begin
      top_next.state = (qs_evt && !i_fault) ? ST_QSTOP : ST_STOP;
      top_next.kind = dec_kind;
      top_next.sw_off = dec_off;
      top_next.qs_hold = dec_hold && qs_evt && !i_fault;
      top_next.pause = 1'b0;
    end else if (i_ctrl_word[smap_pkg::CW_PAUSE_BIT]) begin
      // Pause keeps the power stage on
      top_next.state = ST_PAUSE;
      top_next.kind = dec_kind;
      top_next.sw_off = 1'b0;
      top_next.qs_hold = 1'b0;
      top_next.pause = 1'b1;
    end else begin
      top_next.state = ST_RUN;
      top_next.kind = smap_pkg::KIND_NONE;
      top_next.sw_off = 1'b0;
      top_next.qs_hold = 1'b0;
      top_next.pause = 1'b0;
    end
    top_next.qs_on = (top_next.state == ST_QSTOP); // Registered copy so the output needs no decode
    // Deceleration handed to the profile generator
    if (top_next.state != ST_RUN) begin
      unique case (dec_kind)
        smap_pkg::KIND_QUICK: top_next.decel = top_reg.fast_decel;
        smap_pkg::KIND_RAMP: top_next.decel = top_reg.prof_decel;
        default: top_next.decel = 32'h0000_0000;
      endcase
    end else if (i_work_mode == smap_pkg::MODE_PROFILE_A || i_work_mode == smap_pkg::MODE_PROFILE_B) begin
      top_next.decel = top_reg.prof_decel;
    end else begin
      top_next.decel = 32'h0000_0000;
    end
    // Temperature; a missing sensor must not raise a heat alarm
    top_next.temp = i_temp_sensor_ok ? i_motor_temp : smap_pkg::TEMP_NO_SENSOR;
    top_next.heat_alarm = i_temp_sensor_ok && ($signed(i_motor_temp) > $signed(top_reg.heat_limit));
    // Supply alarms
    top_next.alarm = 16'h0000;
    top_next.alarm[smap_pkg::ALARM_OVER_BIT] = i_supply_volts > top_reg.high_limit;
    top_next.alarm[smap_pkg::ALARM_UNDER_BIT] = i_supply_volts < top_reg.low_limit;
    top_next.chop_on = i_supply_volts >= top_reg.chop;
    top_next.sim_en = i_enc_is_comm && (top_reg.sim_active != 16'h0000);
    top_next.sim_out = top_next.sim_en ? top_next.sim_active : 16'h0000;
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      top_reg <= '0;
      top_reg.state <= ST_RUN;
      top_reg.fast_sel <= smap_pkg::SEL_RST;
      top_reg.enw_sel <= smap_pkg::SEL_RST;
      top_reg.dis_sel <= smap_pkg::SEL_RST;
      top_reg.fault_sel <= smap_pkg::SEL_RST;
      top_reg.pause_sel <= smap_pkg::PAUSE_SEL_RST;
      top_reg.fast_decel <= smap_pkg::FAST_DECEL_RST;
      top_reg.prof_decel <= smap_pkg::PROF_DECEL_RST;
      top_reg.heat_limit <= smap_pkg::HEAT_LIMIT_RST;
      top_reg.low_limit <= smap_pkg::LOW_LIMIT_RST;
      top_reg.chop <= smap_pkg::CHOP_RST;
      top_reg.high_limit <= smap_pkg::HIGH_LIMIT_RST;
      top_reg.src <= smap_pkg::PARAM_SRC_RST;
      top_reg.temp <= smap_pkg::TEMP_NO_SENSOR;
    end else begin
      top_reg <= top_next;
    end
  end

  // Outputs straight from the state register
  assign o_ack = top_reg.ack;
  assign o_err = top_reg.err;
  assign o_rdata = top_reg.rdata;
  assign o_stop_kind = top_reg.kind;
  assign o_switch_off = top_reg.sw_off;
  assign o_qs_active = top_reg.qs_on;
  assign o_pause_active = top_reg.pause;
  assign o_decel_rate = top_reg.decel;
  assign o_temp_reading = top_reg.temp;
  assign o_heat_alarm = top_reg.heat_alarm;
  assign o_alarm_status = top_reg.alarm;
  assign o_chopper_on = top_reg.chop_on;
  assign o_param_source = top_reg.src;
  assign o_boot_pulse = top_reg.boot;
  assign o_restart_pulse = top_reg.rst_pulse;
  assign o_sim_enc_en = top_reg.sim_en;
  assign o_sim_enc_res = top_reg.sim_out;

  // ==========================================================
  // Checks
  qs_entry_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ctrl_word == smap_pkg::CW_QUICK_STOP && !i_fault) |=> o_qs_active)
    else $error("quick stop word did not enter quick stop");
  qs_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_qs_active && top_reg.qs_hold) |-> !o_switch_off)
    else $error("holding quick stop switched off");
  winding_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_fault && top_reg.fault_sel == smap_pkg::SEL_WINDING) |=> o_stop_kind == smap_pkg::KIND_WINDING)
    else $error("winding brake not applied");
  shutdown_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!i_drive_enable && !i_fault && !qs_evt && !i_disable_req) |=> (o_stop_kind != smap_pkg::KIND_NONE))
    else $error("enable withdrawal gave no stop");
  pause_on_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_pause_active |-> (!o_switch_off && o_stop_kind != smap_pkg::KIND_FREE))
    else $error("pause switched motor off");
  fast_decel_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_stop_kind == smap_pkg::KIND_QUICK) |-> (o_decel_rate == $past(top_reg.fast_decel)))
    else $error("quick stop used wrong deceleration");
  temp_default_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_temp_sensor_ok |=> (o_temp_reading == smap_pkg::TEMP_NO_SENSOR && !o_heat_alarm))
    else $error("missing sensor not shown as -40");
  volt_alarm_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_supply_volts > top_reg.high_limit) |=> o_alarm_status[smap_pkg::ALARM_OVER_BIT])
    else $error("overvoltage not flagged");
  sel_reject_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_wr && i_addr == smap_pkg::ADDR_ENW_SEL && !std_ok(i_wdata)) |=> (o_err && $stable(top_reg.enw_sel)))
    else $error("illegal selection was stored");
  restart_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_wr && i_addr == smap_pkg::ADDR_RESTART && i_wdata == smap_pkg::CMD_BOOT) ##1
    !(i_req && i_wr && i_addr == smap_pkg::ADDR_RESTART && i_wdata == smap_pkg::CMD_BOOT)
    |-> o_boot_pulse ##1 !o_boot_pulse)
    else $error("bootloader pulse wrong");

endmodule // smap_top
`default_nettype wire

// File: dv/smap_host.sv
// Host controller model issuing single parameter accesses
`timescale 1ns/1ps
`default_nettype none
module smap_host (
  // Clock and answer
  input wire logic i_clk,
  input wire logic i_ack,
  input wire logic i_err,
  input wire logic [15:0] i_rdata,
  // Request
  output logic o_req = 1'b0,
  output logic o_wr = 1'b0,
  output logic [15:0] o_addr = 16'h0000,
  output logic [15:0] o_wdata = 16'h0000
);
  // ==========================================================
  // Access: one-cycle pulse, answer taken one edge later
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic ack, output logic err, output logic [15:0] rd);
    @(posedge i_clk);
    o_req <= 1'b1;
    o_wr <= w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_req <= 1'b0;
    // Stale lines are inverted so nothing relies on them after release
    o_addr <= ~a;
    o_wdata <= ~d;
    @(posedge i_clk);
    ack = i_ack;
    err = i_err;
    rd = i_rdata;
  endtask
endmodule // smap_host
`default_nettype wire

// File: dv/test_stop_mode_and_alarm_params.sv
// Self-checking bench for the stop mode and alarm parameter bank
`timescale 1ns/1ps
`default_nettype none
module test_stop_mode_and_alarm_params;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_limit_pin = 1'b0, i_estop_pin = 1'b0, i_temp_sensor_ok = 1'b1;
  logic i_drive_enable = 1'b1, i_disable_req = 1'b0, i_fault = 1'b0, i_enc_is_comm = 1'b1;
  logic [15:0] i_ctrl_word = 16'h0000, i_motor_temp = 16'h0019, i_supply_volts = 16'h0018;
  logic [7:0] i_work_mode = 8'h01;
  logic i_req, i_wr, o_ack, o_err, o_switch_off, o_qs_active, o_pause_active, o_heat_alarm, o_chopper_on;
  logic o_boot_pulse, o_restart_pulse, o_sim_enc_en, w, e, ack, err;
  logic [15:0] i_addr, i_wdata, o_rdata, o_temp_reading, o_alarm_status, o_sim_enc_res, a, d, r, rd;
  logic [2:0] o_stop_kind;
  logic [31:0] o_decel_rate;
  logic [7:0] o_param_source;
  int bad_count = 0, comparisons = 0, boots = 0, restarts = 0;
  // Rows: {write, refused}, address, write data, read data expected
  logic [49:0] rows [22] = '{{2'h0, 16'h3400, 16'h0000, 16'h0000}, {2'h0, 16'h3410, 16'h0000, 16'h0000},
    {2'h0, 16'h3420, 16'h0000, 16'h0000}, {2'h0, 16'h3430, 16'h0000, 16'h0001}, {2'h0, 16'h3440, 16'h0000, 16'h0000},
    {2'h0, 16'h3300, 16'h0000, 16'hEE48}, {2'h0, 16'h4C00, 16'h0000, 16'h2710}, {2'h0, 16'h7180, 16'h0000, 16'h0064},
    {2'h0, 16'h8670, 16'h0000, 16'h0012}, {2'h0, 16'h8680, 16'h0000, 16'h003F}, {2'h0, 16'h8690, 16'h0000, 16'h0046},
    {2'h0, 16'h7200, 16'h0000, 16'h0002}, {2'h2, 16'h3400, 16'h0006, 16'h0000}, {2'h0, 16'h3400, 16'h0000, 16'h0006},
    {2'h3, 16'h3410, 16'h0005, 16'h0000}, {2'h0, 16'h3410, 16'h0000, 16'h0000}, {2'h3, 16'h3430, 16'h0000, 16'h0000},
    {2'h2, 16'h3420, 16'h0012, 16'h0000}, {2'h0, 16'h3420, 16'h0000, 16'h0012}, {2'h3, 16'h7190, 16'h0001, 16'h0000},
    {2'h1, 16'h1234, 16'h0000, 16'h0000}, {2'h2, 16'h7210, 16'h1F40, 16'h0000}};
  // ==========================================================
  // Clock, design, host model, pulse counters
  initial forever #25 i_clk = ~i_clk;
  smap_top smap_top_inst (.*);
  smap_host smap_host_inst (.i_clk(i_clk), .i_ack(o_ack), .i_err(o_err), .i_rdata(o_rdata), .o_req(i_req),
    .o_wr(i_wr), .o_addr(i_addr), .o_wdata(i_wdata));
  always @(posedge i_clk) begin
    boots <= boots + int'(o_boot_pulse === 1'b1);
    restarts <= restarts + int'(o_restart_pulse === 1'b1);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the hundred or so cycles the run needs
  initial begin
    #100_000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    check(o_param_source, 8'h02);
    for (int k = 0; k < 22; k++) begin
      {w, e, a, d, r} = rows[k];
      smap_host_inst.access(w, a, d, ack, err, rd);
      check({ack, err}, {1'b1, e});
      if (!e) check(rd, r);
    end
    // Resolution only goes live once the host restarts the drive
    check(o_sim_enc_en, 1'b0);
    check(o_decel_rate, 32'h0000_2710);
    smap_host_inst.access(1'b1, 16'h2F00, 16'hAA55, ack, err, rd);
    smap_host_inst.access(1'b1, 16'h2F00, 16'h55AA, ack, err, rd);
    smap_host_inst.access(1'b1, 16'h3440, 16'h0012, ack, err, rd);
    check({restarts[15:0], boots[15:0]}, {16'd1, 16'd1});
    check({o_sim_enc_en, o_sim_enc_res}, {1'b1, 16'h1F40});
    i_ctrl_word <= 16'h000B;
    repeat (2) @(posedge i_clk);
    check({o_qs_active, o_switch_off, o_stop_kind}, {1'b1, 1'b0, 3'h3});
    check(o_decel_rate, 32'h0000_EE48);
    // Pause, then disable, fault and shutdown stops
    i_ctrl_word <= 16'h0100;
    repeat (2) @(posedge i_clk);
    check({o_pause_active, o_switch_off, o_stop_kind, o_decel_rate[15:0]}, {1'b1, 1'b0, 3'h2, 16'h2710});
    i_ctrl_word <= 16'h0000;
    i_disable_req <= 1'b1;
    repeat (2) @(posedge i_clk);
    check({o_qs_active, o_switch_off, o_stop_kind}, {1'b0, 1'b1, 3'h4});
    i_disable_req <= 1'b0;
    i_fault <= 1'b1;
    i_ctrl_word <= 16'h000B;
    repeat (2) @(posedge i_clk);
    check({o_qs_active, o_switch_off, o_stop_kind}, {1'b0, 1'b1, 3'h4});
    i_fault <= 1'b0;
    i_ctrl_word <= 16'h0000;
    i_drive_enable <= 1'b0;
    repeat (2) @(posedge i_clk);
    check({o_switch_off, o_stop_kind, o_pause_active}, {1'b1, 3'h1, 1'b0});
    i_drive_enable <= 1'b1;
    i_estop_pin <= 1'b1;
    i_supply_volts <= 16'h0050;
    i_motor_temp <= 16'h0078;
    repeat (4) @(posedge i_clk);
    check(o_qs_active, 1'b1);
    check({o_alarm_status, o_heat_alarm, o_chopper_on}, {16'h0020, 1'b1, 1'b1});
    i_temp_sensor_ok <= 1'b0;
    i_supply_volts <= 16'h0010;
    i_enc_is_comm <= 1'b0;
    repeat (2) @(posedge i_clk);
    check({o_temp_reading, o_heat_alarm}, {16'hFFD8, 1'b0});
    check({o_alarm_status[6:5], o_chopper_on, o_sim_enc_en}, {2'b10, 1'b0, 1'b0});
    // Mid-run reset brings back the stored parameter source and disable selection defaults
    i_estop_pin <= 1'b0;
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    check({o_qs_active, o_stop_kind, o_param_source}, {1'b0, 3'h0, 8'h02});
    i_arst_n <= 1'b1;
    smap_host_inst.access(1'b0, 16'h3420, 16'h0000, ack, err, rd);
    check(rd, 16'h0000);
    tally_and_finish();
  end
endmodule // test_stop_mode_and_alarm_params
`default_nettype wire
